// ---- hw/tolcg_map.vh ----
`ifndef TOLCG_MAP_VH
`define TOLCG_MAP_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TOLCG_OFF_MODE 8'h00
`define TOLCG_OFF_OUTCTL 8'h04
`define TOLCG_OFF_IRQ 8'h08
`define TOLCG_OFF_CMP1 8'h0C
`define TOLCG_OFF_CMP2 8'h10
`define TOLCG_OFF_COUNT 8'h14
`define TOLCG_OFF_CAP_CTL 8'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TOLCG_MODE_LO 2
`define TOLCG_MODE_HI 3
`define TOLCG_EDGE_INV 1
`define TOLCG_LVR 2
`define TOLCG_LVS 3
`define TOLCG_INV2_EN 4
`define TOLCG_OUT_LVL 8
`define TOLCG_IF1 0
`define TOLCG_IF2 1
`define TOLCG_MK1 8
`define TOLCG_MK2 9
`define TOLCG_CAPSEL1 0
`define TOLCG_CAPSEL2 1
// ----------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------
`define TOLCG_MODE_STOP 2'b00
`define TOLCG_MODE_FREE 2'b01
`define TOLCG_MODE_EDGE 2'b10
`define TOLCG_MODE_MATCH 2'b11
`define TOLCG_RST_16 16'h0000
`define TOLCG_RST_MASK 2'b11
`define TOLCG_CNT_ONE 16'h0001
`endif

// ---- hw/tolcg_top.v ----
// Implementation choices: the AXI4-Lite register port and the address map.
`include "tolcg_map.vh"

// Notes on behaviour
// - While stopped, level controls 10 drive output high; 11 is never written.
// - Level controls 01 force output low; returning to 00 keeps the level.
// - Level controls work with the mode field at 00.
// - Mode field 01, 10 or 11 starts the counter.
// - On start the output begins from the level set while stopped.
// - Output toggles on each first compare match in compare role, unless a second compare match in compare role with inv2 set falls in the same cycle.
// - First match after start may be one count clock early or late.
// - A capture edge during a capture read still captures.
// - A capture edge during a capture read still raises its irq.
// - Capture/compare contents are not retained after stop.
// - Mode 01 is free running; 10 runs likewise and clears on each first input edge.
// - Counter equal to first compare, with the first register in compare role, raises first irq and toggles output.
module tolcg_top (
   input wire clk,
   input wire rst_b,
   input wire count_en,
   input wire first_capture_input,
   input wire second_capture_input,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   output wire timer_output_pin,
   output wire first_compare_irq,
   output wire second_compare_irq
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // The count pulse and both capture pins come from outside the clock
   // domain, so each passes two flip-flops before any logic reads it.
   // A third stage only remembers the previous settled level, so that a
   // rising edge can be found without reading the first stage.
   // The cost is a latency of about two clocks from pin to tick.
   // Edges closer together than that latency may be merged or lost.
   // Because every stage resets low, a pin held high through reset
   // shows one rising edge just after reset is released.
   reg [2:0] sync1_q;
   reg [2:0] sync2_q;
   reg [2:0] sync3_q;
   always @(posedge clk) begin
      if (!rst_b) begin
         sync1_q <= 3'b000;
         sync2_q <= 3'b000;
         sync3_q <= 3'b000;
      end else begin
         sync1_q <= {count_en, second_capture_input, first_capture_input};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end
   wire tick = sync2_q[2] & ~sync3_q[2];
   wire in1_rise = sync2_q[0] & ~sync3_q[0];
   wire in2_rise = sync2_q[1] & ~sync3_q[1];

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   // Address and data are taken in either order and held until both
   // have arrived; the write then lands in the same cycle that raises
   // the response.
   // Ready is withheld while a response waits, so only one write and
   // one read are ever under way.
   // The read answer is registered one cycle after the address is taken.
   // The read address is used straight from the bus because it is only
   // looked at in the cycle in which it is taken.
   // Unmapped read offsets answer with a slave error and read as zero; writes get one only above offset 0x18.
   // Narrow strobes are honoured per register, not per byte: the compare
   // words need both low bytes, the masks need byte one, and all other
   // fields need byte zero.
   reg aw_got_q;
   reg w_got_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [1:0] rresp_q;
   reg [31:0] rdata_q;
   assign s_axi_awready = ~aw_got_q & ~bvalid_q;
   assign s_axi_wready = ~w_got_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   wire wr_go = aw_got_q & w_got_q & ~bvalid_q;
   wire rd_go = s_axi_arvalid & ~rvalid_q;
   wire wr_lo = wr_go & wstrb_q[0];
   wire wr_hi = wr_go & wstrb_q[1];
   wire [7:0] rd_addr = s_axi_araddr;

   // ----------------------------------------------------------------
   // Control state
   // ----------------------------------------------------------------
   // Counting and compare matches are gated by the synchronised tick, so the first
   // match after a start may land one tick early or late, depending on
   // where the start falls against the count pulse.
   // A register in capture role gets no irq or toggle from a compare match (mode 11 still clears on a first-compare match); its
   // interrupt then comes from the capture edge instead.
   reg [1:0] mode_q;
   reg edge_inv_q;
   reg lvs_q;
   reg lvr_q;
   reg inv2_q;
   reg out_q;
   reg [1:0] if_q;
   reg [1:0] mk_q;
   reg [1:0] capsel_q;
   reg [15:0] cmp1_q;
   reg [15:0] cmp2_q;
   reg [15:0] cnt_q;
   reg started_q;
   wire running = (mode_q != `TOLCG_MODE_STOP);
   wire match1 = running & tick & (cnt_q == cmp1_q);
   wire match2 = running & tick & (cnt_q == cmp2_q);
   // Capture on an edge only when the register is in capture role.
   wire cap1 = running & capsel_q[0] & in2_rise;
   wire cap2 = running & capsel_q[1] & in1_rise;
   wire ev1 = capsel_q[0] ? cap1 : match1;
   wire ev2 = capsel_q[1] ? cap2 : match2;
   wire edge_clear = (mode_q == `TOLCG_MODE_EDGE) & in1_rise;
   wire match_clear = (mode_q == `TOLCG_MODE_MATCH) & match1;
   wire wr_outctl = wr_lo & (awaddr_q == `TOLCG_OFF_OUTCTL);
   assign timer_output_pin = out_q;
   assign first_compare_irq = if_q[0] & ~mk_q[0];
   assign second_compare_irq = if_q[1] & ~mk_q[1];

   always @(posedge clk) begin
      if (!rst_b) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
         rvalid_q <= 1'b0;
         rresp_q <= 2'b00;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q > `TOLCG_OFF_CAP_CTL) ? 2'b10 : 2'b00;
         end else if (bvalid_q & s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= 2'b00;
            rdata_q <= 32'h0000_0000;
            case (rd_addr)
               `TOLCG_OFF_MODE: rdata_q[3:1] <= {mode_q, edge_inv_q};
               `TOLCG_OFF_OUTCTL: rdata_q[8:2] <= {out_q, 3'b000, inv2_q, lvs_q, lvr_q};
               `TOLCG_OFF_IRQ: rdata_q[9:0] <= {mk_q, 6'b00_0000, if_q};
               // A read in the same cycle as a capture returns the value from before it.
               `TOLCG_OFF_CMP1: rdata_q[15:0] <= cmp1_q;
               `TOLCG_OFF_CMP2: rdata_q[15:0] <= cmp2_q;
               `TOLCG_OFF_COUNT: rdata_q[15:0] <= cnt_q;
               `TOLCG_OFF_CAP_CTL: rdata_q[1:0] <= capsel_q;
               default: rresp_q <= 2'b10;
            endcase
         end else if (rvalid_q & s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Timer channel
   // ----------------------------------------------------------------
   // All updates act on the clock edge at which the bus write lands.
   // Level writes are obeyed only while stopped; a running channel keeps
   // its own output so that a stray write cannot glitch the pin.
   // The compare words are cleared one cycle after a stop, so no user of
   // them can come to rely on a value surviving a stop.
   // A capture wins over a bus write to the same register in one cycle,
   // since losing a measured edge is worse than losing a rewrite.
   // Interrupt flags are sticky: a same-cycle event beats a clear, so an
   // event is never lost to a slow handler.
   always @(posedge clk) begin
      if (!rst_b) begin
         mode_q <= `TOLCG_MODE_STOP;
         edge_inv_q <= 1'b0;
         lvs_q <= 1'b0;
         lvr_q <= 1'b0;
         inv2_q <= 1'b0;
         out_q <= 1'b0;
         if_q <= 2'b00;
         mk_q <= `TOLCG_RST_MASK;
         capsel_q <= 2'b00;
         cmp1_q <= `TOLCG_RST_16;
         cmp2_q <= `TOLCG_RST_16;
         cnt_q <= `TOLCG_RST_16;
         started_q <= 1'b0;
      end else begin
         if (wr_lo & (awaddr_q == `TOLCG_OFF_MODE)) begin
            mode_q <= wdata_q[`TOLCG_MODE_HI:`TOLCG_MODE_LO];
            edge_inv_q <= wdata_q[`TOLCG_EDGE_INV];
         end
         if (wr_outctl) begin
            lvs_q <= wdata_q[`TOLCG_LVS];
            lvr_q <= wdata_q[`TOLCG_LVR];
            inv2_q <= wdata_q[`TOLCG_INV2_EN];
         end
         if (wr_lo & (awaddr_q == `TOLCG_OFF_CAP_CTL)) begin
            capsel_q <= wdata_q[1:0];
         end
         if (wr_go & (awaddr_q == `TOLCG_OFF_IRQ)) begin
            if (wstrb_q[1]) begin
               mk_q <= wdata_q[`TOLCG_MK2:`TOLCG_MK1];
            end
         end
         // Writing a zero clears a flag; a same-cycle event wins.
         if (wr_lo & (awaddr_q == `TOLCG_OFF_IRQ)) begin
            if_q <= (if_q & wdata_q[1:0]) | {ev2, ev1};
         end else begin
            if_q <= if_q | {ev2, ev1};
         end
         // Level controls act at once; 00 holds, 11 is treated as hold.
         if (wr_outctl & ~running) begin
            if (wdata_q[`TOLCG_LVS] & ~wdata_q[`TOLCG_LVR]) begin
               out_q <= 1'b1;
            end else if (~wdata_q[`TOLCG_LVS] & wdata_q[`TOLCG_LVR]) begin
               out_q <= 1'b0;
            end
         end else if (running) begin
            // The output keeps its stopped level into the run.
            // A real compare match may invert, never a capture; with edge_inv_q set so may a first-input edge.
            if ((match1 & ~capsel_q[0]) ^ (match2 & inv2_q & ~capsel_q[1])) begin
               out_q <= ~out_q;
            end else if (edge_inv_q & in1_rise) begin
               out_q <= ~out_q;
            end
         end
         started_q <= running;
         if (!running) begin
            cnt_q <= `TOLCG_RST_16;
            if (started_q) begin
               // Stop leaves the compare words meaningless.
               cmp1_q <= `TOLCG_RST_16;
               cmp2_q <= `TOLCG_RST_16;
            end
         end else if (edge_clear | match_clear) begin
            cnt_q <= `TOLCG_RST_16;
         end else if (tick) begin
            cnt_q <= cnt_q + `TOLCG_CNT_ONE;
         end
         if (cap1) begin
            cmp1_q <= cnt_q;
         end else if (wr_lo & wr_hi & (awaddr_q == `TOLCG_OFF_CMP1)) begin
            cmp1_q <= wdata_q[15:0];
         end
         if (cap2) begin
            cmp2_q <= cnt_q;
         end else if (wr_lo & wr_hi & (awaddr_q == `TOLCG_OFF_CMP2)) begin
            cmp2_q <= wdata_q[15:0];
         end
      end
   end
endmodule // tolcg_top

// ---- sim/tolcg_props.sv ----
module tolcg_props (
   input wire clk,
   input wire rst_b,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire timer_output_pin,
   input wire first_compare_irq,
   input wire second_compare_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   wire lvl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && (s_axi_awaddr == 8'h04);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_reset_out_low: assert property ($rose(rst_b) |-> !timer_output_pin
      && !first_compare_irq && !second_compare_irq) else $error("outputs not low after reset");
   a_level_set_high: assert property (lvl_wr && s_axi_wdata[3:2] == 2'b10
      |-> ##[1:2] timer_output_pin) else $error("level set did not drive high");
   a_level_clear_low: assert property (lvl_wr && s_axi_wdata[3:2] == 2'b01
      |-> ##[1:2] !timer_output_pin) else $error("level clear did not drive low");
   a_level_zero_hold: assert property (lvl_wr && s_axi_wdata[3:2] == 2'b00
      |-> ##1 $stable(timer_output_pin) [*2]) else $error("level 00 changed output");
   a_unmapped_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
      |-> ##[1:2] s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
endmodule // tolcg_props

bind tolcg_top tolcg_props i_props (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .timer_output_pin(timer_output_pin), .first_compare_irq(first_compare_irq),
   .second_compare_irq(second_compare_irq));

// ---- sim/tolcg_far_end.sv ----
module tolcg_far_end (
   input wire clk,
   output logic count_en,
   output logic first_capture_input,
   input wire timer_output_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      count_en = 1'b0;
      first_capture_input = 1'b0;
   end
   // Pulses are held for several clocks so the two-stage synchroniser sees each one.
   task tick(input int n);
      repeat (n) begin
         @(posedge clk) count_en <= 1'b1;
         repeat (2) @(posedge clk);
         count_en <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
   task edge1;
      @(posedge clk) first_capture_input <= 1'b1;
      repeat (5) @(posedge clk);
      first_capture_input <= 1'b0;
   endtask
endmodule // tolcg_far_end

// ---- sim/timer_output_level_and_capture_guard_tb_top.sv ----
`include "tolcg_map.vh"
module timer_output_level_and_capture_guard_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, v;
   logic [3:0] wstrb = 0;
   wire awready, wready, bvalid, arready, rvalid, pin, irq1, irq2, cnt_en, cap1;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int err_total = 0, tests_run = 0;
   always #50 clk = ~clk;
   tolcg_far_end i_far (.clk(clk), .count_en(cnt_en), .first_capture_input(cap1),
      .timer_output_pin(pin));
   tolcg_top i_dut (.clk(clk), .rst_b(rst_b), .count_en(cnt_en), .first_capture_input(cap1),
      .second_capture_input(1'b0), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer_output_pin(pin), .first_compare_irq(irq1), .second_compare_irq(irq2));
   task end_sim;
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Ready is looked at in the low half, where it already equals its value at the next edge.
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      @(posedge clk);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'b111};
      fork
         begin do @(negedge clk); while (!awready); @(posedge clk) awvalid <= 0; end
         begin do @(negedge clk); while (!wready); @(posedge clk) wvalid <= 0; end
      join
      do @(negedge clk); while (!bvalid);
      chk("bresp", er, bresp);
      @(posedge clk) bready <= 0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'b00);
      @(posedge clk) {araddr, arvalid, rready} <= {a, 2'b11};
      do @(negedge clk); while (!arready);
      @(posedge clk) arvalid <= 0;
      do @(negedge clk); while (!rvalid);
      d = rdata;
      chk("rresp", er, rresp);
      @(posedge clk) rready <= 0;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1;
      rd(`TOLCG_OFF_IRQ, v); chk("irq", 32'h0000_0300, v);
      rd(`TOLCG_OFF_OUTCTL, v); chk("level", 0, v[8]);
      wr(`TOLCG_OFF_OUTCTL, 32'h0000_0008); chk("pin", 1, pin);
      wr(`TOLCG_OFF_OUTCTL, 32'h0000_0004); chk("pin", 0, pin);
      wr(`TOLCG_OFF_OUTCTL, 32'h0000_0008); wr(`TOLCG_OFF_OUTCTL, 0);
      chk("pin", 1, pin);
      wr(`TOLCG_OFF_CAP_CTL, 32'h0000_0002);
      wr(`TOLCG_OFF_CMP1, 32'h0000_0003); wr(`TOLCG_OFF_MODE, 32'h0000_0004);
      chk("start", 1, pin);
      i_far.tick(5); rd(`TOLCG_OFF_COUNT, v); chk("count", 5, v);
      chk("toggle", 0, pin);
      wr(`TOLCG_OFF_IRQ, 32'h0000_0201); chk("irq1", 1, irq1);
      wr(`TOLCG_OFF_IRQ, 32'h0000_0200); chk("irq1", 0, irq1);
      fork i_far.edge1(); rd(`TOLCG_OFF_CMP2, v); join
      rd(`TOLCG_OFF_CMP2, v); chk("capture", 5, v);
      wr(`TOLCG_OFF_IRQ, 32'h0000_0002); chk("irq2", 1, irq2);
      wr(`TOLCG_OFF_IRQ, 32'h0000_0203); wr(`TOLCG_OFF_OUTCTL, 0);
      wr(`TOLCG_OFF_CMP2, 32'h0000_0009); i_far.tick(1);
      wr(`TOLCG_OFF_OUTCTL, 32'h0000_0010); wr(`TOLCG_OFF_IRQ, 32'h0000_0201);
      wr(`TOLCG_OFF_IRQ, 32'h0000_0003); chk("irq2", 0, irq2);
      rd(`TOLCG_OFF_CMP2, v); chk("cmp2", 9, v);
      for (int m = 1; m < 4; m++) begin
         wr(`TOLCG_OFF_MODE, 0); wr(`TOLCG_OFF_CMP1, 32'h0000_0100);
         wr(`TOLCG_OFF_CMP2, 32'h0000_0200);
         wr(`TOLCG_OFF_MODE, m << 2); i_far.tick(2);
         rd(`TOLCG_OFF_COUNT, v); chk("running", 1, v != 0);
      end
      wr(`TOLCG_OFF_MODE, 0); wr(`TOLCG_OFF_OUTCTL, 32'h0000_0008);
      wr(`TOLCG_OFF_MODE, 32'h0000_0006); chk("restart", 1, pin);
      i_far.edge1(); repeat (2) @(posedge clk); chk("edge_inv", 0, pin);
      wr(`TOLCG_OFF_MODE, 0);
      rd(8'h1C, v, 2'b10); chk("rdata", 0, v);
      wr(8'h1C, 32'h0000_0001, 2'b10);
      end_sim();
   end
endmodule // timer_output_level_and_capture_guard_tb_top
